/* shared/dcr_pkg.sv */
// Constants, field positions and types of the four-channel DMA register block.
// Assumes a byte-wide I/O port with a 4-bit register offset.
`default_nettype none
package dcr_pkg;
    localparam int          CH_NUM         = 4;
    localparam int          CH_W           = 2;
    localparam int          ADDR_W         = 16;
    localparam int          FIFO_DEPTH     = 8;
    localparam int          SYNC_W         = 2 + 4 + 8 + CH_NUM;
    // Channel n address sits at 2n, its word count at 2n+1.
    localparam logic [3:0]  OFS_CH_ADDR0   = 4'h0;
    localparam logic [3:0]  OFS_CH_COUNT0  = 4'h1;
    localparam logic [3:0]  OFS_COMMAND    = 4'h8;
    localparam logic [3:0]  OFS_MODE       = 4'hB;
    localparam logic [3:0]  OFS_CLR_PTR    = 4'hC;
    localparam logic [3:0]  OFS_MASTER_CLR = 4'hD;
    localparam logic [3:0]  OFS_CLR_MODE   = 4'hE;
    localparam int          CMD_ADDR_HOLD  = 1;
    localparam int          CMD_DISABLE    = 2;
    localparam int          CMD_ROTATE     = 4;
    localparam int          CMD_EXT_WRITE  = 5;
    localparam int          CMD_REQ_LOW    = 6;
    localparam int          CMD_ACK_HIGH   = 7;
    localparam logic [7:0]  COMMAND_RESET  = 8'h00;
    localparam logic [5:0]  MODE_RESET     = 6'h00;
    localparam logic [1:0]  MODE_RD_CHAN   = 2'h3;
    // Fields of the six stored mode bits (write bits 7:2 shifted down by 2).
    localparam int          MODE_TYPE_LSB  = 0;
    localparam int          MODE_AUTOINIT  = 2;
    localparam int          MODE_DOWN      = 3;
    localparam int          MODE_SVC_LSB   = 4;
    localparam logic [15:0] COUNT_WRAP     = 16'h0000;
    localparam int          XFER_W         = 1 + CH_W + ADDR_W;

    typedef enum logic [1:0] {
        DCR_XF_VERIFY = 2'h0,
        DCR_XF_WRITE  = 2'h1,
        DCR_XF_READ   = 2'h2,
        DCR_XF_NONE   = 2'h3
    } dcr_xfer_t;

    typedef enum logic [1:0] {
        DCR_SV_DEMAND = 2'h0,
        DCR_SV_SINGLE = 2'h1,
        DCR_SV_BLOCK  = 2'h2,
        DCR_SV_CASC   = 2'h3
    } dcr_svc_t;

    typedef enum logic [2:0] {
        DCR_ST_IDLE = 3'h0,
        DCR_ST_S1   = 3'h1,
        DCR_ST_S2   = 3'h3,
        DCR_ST_S3   = 3'h2,
        DCR_ST_S4   = 3'h6,
        DCR_ST_CASC = 3'h4
    } dcr_state_t;
endpackage
`default_nettype wire

/* shared/dcr_stream_if.sv */
// Valid/ready stream carrying one word between modules of the DMA block.
// Assumes both ends share one clock.
`default_nettype none
interface dcr_stream_if #(parameter int W = 8);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

/* src/dcr_fifo.sv */
// Flip-flop FIFO between the transfer engine and the transfer-record output.
// Assumes the same clock and reset on both sides.
`default_nettype none
module dcr_fifo
    import dcr_pkg::*;
#(
    parameter int W     = XFER_W,
    parameter int DEPTH = FIFO_DEPTH
)(
    input  wire logic  i_clk,
    input  wire logic  i_rst_n,
    dcr_stream_if.snk  in_s,
    dcr_stream_if.src  out_s
);
    localparam int AW = $clog2(DEPTH);

    initial
    begin
        if (DEPTH < 2 || (1 << AW) != DEPTH)
            $error("Depth must be a power of two of at least 2.");
    end

    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0]   fill;
    logic          push;
    logic          pop;

    assign in_s.ready  = (fill != (AW+1)'(DEPTH));
    assign out_s.valid = (fill != '0);
    assign out_s.data  = mem[rd_ptr];
    assign push        = in_s.valid && in_s.ready;
    assign pop         = out_s.valid && out_s.ready;

    always_ff @(posedge i_clk)
    begin
        if (push)
            mem[wr_ptr] <= in_s.data;
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            fill   <= '0;
        end
        else
        begin
            if (push)
                wr_ptr <= wr_ptr + 1'b1;
            if (pop)
                rd_ptr <= rd_ptr + 1'b1;
            if (push && !pop)
                fill <= fill + 1'b1;
            else if (pop && !push)
                fill <= fill - 1'b1;
        end
    end
endmodule
`default_nettype wire

/* src/dcr_arbiter.sv */
// Picks one pending channel, fixed or rotating priority.
// Assumes requests are already masked and polarity-corrected.
`default_nettype none
module dcr_arbiter
    import dcr_pkg::*;
#(
    parameter int N = CH_NUM
)(
    input  wire logic [N-1:0]         i_req,
    input  wire logic                 i_rotate,
    input  wire logic [$clog2(N)-1:0] i_last,
    output logic                      o_valid,
    output logic [$clog2(N)-1:0]      o_pick
);
    initial
    begin
        if (N < 2)
            $error("At least two channels are needed.");
    end

    always_comb
    begin
        int start;
        int idx;
        start   = 0;
        idx     = 0;
        o_valid = 1'b0;
        o_pick  = '0;
        // Rotating priority puts the last served channel at the bottom.
        start = i_rotate ? (int'(i_last) + 1) : 0;
        for (int k = 0; k < N; k++)
        begin
            idx = (start + k) % N;
            if (!o_valid && i_req[idx])
            begin
                o_valid = 1'b1;
                o_pick  = ($clog2(N))'(idx);
            end
        end
    end
endmodule
`default_nettype wire

/* src/dcr_top.sv */
// Register set and transfer sequencer of a four-channel DMA controller.
// Assumes a CPU on a byte I/O port with low-active strobes, asynchronous
// to I_CORE_CLK, holding address and data stable around each strobe.
`default_nettype none
module dcr_top
    import dcr_pkg::*;
(
    input  wire logic              I_CORE_CLK,
    input  wire logic              I_ARST_N,
    input  wire logic              I_IOR_N,
    input  wire logic              I_IOW_N,
    input  wire logic [3:0]        I_ADDR,
    input  wire logic [7:0]        I_DATA,
    output logic [7:0]             O_DATA,
    output logic                   O_DATA_OE,
    input  wire logic [CH_NUM-1:0] I_CHANNEL_REQUEST_LINE,
    output logic [CH_NUM-1:0]      O_CHANNEL_ACKNOWLEDGE_LINE,
    output logic                   O_TC,
    output logic                   O_MEM_RD,
    output logic                   O_MEM_WR,
    output logic                   O_IO_RD,
    output logic                   O_IO_WR,
    output logic                   O_XFER_VALID,
    output logic [ADDR_W-1:0]      O_XFER_ADDR,
    output logic [CH_W-1:0]        O_XFER_CHAN,
    output logic                   O_XFER_TC,
    input  wire logic              I_XFER_READY
);
    logic [SYNC_W-1:0] sync1;
    logic [SYNC_W-1:0] sync2;
    logic              ior_prev;
    logic              iow_prev;
    logic              rd_evt;
    logic              wr_evt;
    logic              ior_act;
    logic              iow_act;
    logic [3:0]        s_addr;
    logic [7:0]        s_data;
    logic [CH_NUM-1:0] s_req;

    logic [7:0]        command;
    logic [5:0]        mode [CH_NUM];
    logic [15:0]       cur_addr [CH_NUM];
    logic [15:0]       base_addr [CH_NUM];
    logic [15:0]       cur_count [CH_NUM];
    logic [15:0]       base_count [CH_NUM];
    logic              high_byte;
    logic [CH_W-1:0]   mode_rd_idx;
    logic [CH_NUM-1:0] mask;

    dcr_state_t        state;
    dcr_state_t        next_state;
    logic [CH_W-1:0]   ch;
    logic [CH_W-1:0]   last_ch;
    logic [CH_NUM-1:0] req_eff;
    logic              arb_valid;
    logic [CH_W-1:0]   arb_pick;
    logic              tc_now;
    logic              step;
    logic              disabled;
    dcr_xfer_t         xtype;
    dcr_svc_t          svc;
    logic              rd_win;
    logic              wr_win;

    // Channel register decode shared by the read and write paths.
    function automatic logic is_chan_reg(input logic [3:0] a);
        return (a < OFS_COMMAND);
    endfunction

    function automatic logic [CH_W-1:0] chan_of(input logic [3:0] a);
        return a[CH_W:1];
    endfunction

    // Strobes, address, data and requests all arrive from pins.
    always_ff @(posedge I_CORE_CLK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
        begin
            sync1 <= {2'h3, {(SYNC_W-2){1'b0}}};
            sync2 <= {2'h3, {(SYNC_W-2){1'b0}}};
        end
        else
        begin
            sync1 <= {I_IOR_N, I_IOW_N, I_ADDR, I_DATA,
                      I_CHANNEL_REQUEST_LINE};
            sync2 <= sync1;
        end
    end

    assign ior_act = !sync2[SYNC_W-1];
    assign iow_act = !sync2[SYNC_W-2];
    assign s_addr  = sync2[SYNC_W-3 -: 4];
    assign s_data  = sync2[CH_NUM +: 8];
    assign s_req   = sync2[CH_NUM-1:0];

    always_ff @(posedge I_CORE_CLK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
        begin
            ior_prev <= 1'b0;
            iow_prev <= 1'b0;
        end
        else
        begin
            ior_prev <= ior_act;
            iow_prev <= iow_act;
        end
    end

    assign rd_evt   = ior_act && !ior_prev;
    assign wr_evt   = iow_act && !iow_prev;
    assign disabled = command[CMD_DISABLE];
    assign xtype    = dcr_xfer_t'(mode[ch][MODE_TYPE_LSB +: 2]);
    assign svc      = dcr_svc_t'(mode[ch][MODE_SVC_LSB +: 2]);
    assign step     = (state == DCR_ST_S4);
    assign tc_now   = step && (cur_count[ch] == COUNT_WRAP);

    always_ff @(posedge I_CORE_CLK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
            command <= COMMAND_RESET;
        else if (wr_evt && s_addr == OFS_MASTER_CLR)
            command <= COMMAND_RESET;
        else if (wr_evt && s_addr == OFS_COMMAND)
            command <= s_data;  // Reserved bits are stored as written.
    end

    // The byte pointer toggles on every channel register access.
    always_ff @(posedge I_CORE_CLK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
            high_byte <= 1'b0;
        else if (wr_evt && (s_addr == OFS_CLR_PTR ||
                            s_addr == OFS_MASTER_CLR))
            high_byte <= 1'b0;
        else if ((wr_evt || rd_evt) && is_chan_reg(s_addr))
            high_byte <= !high_byte;
    end

    always_ff @(posedge I_CORE_CLK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
            mode_rd_idx <= '0;
        else if (wr_evt && (s_addr == OFS_CLR_MODE ||
                            s_addr == OFS_MASTER_CLR))
            mode_rd_idx <= '0;
        else if (rd_evt && s_addr == OFS_MODE)
            mode_rd_idx <= mode_rd_idx + 1'b1;
    end

    generate
        for (genvar g = 0; g < CH_NUM; g++)
        begin : g_chan
            logic cpu_addr_wr;
            logic cpu_cnt_wr;
            logic mine;
            logic reload;
            assign cpu_addr_wr = wr_evt && is_chan_reg(s_addr) &&
                                 !s_addr[0] && chan_of(s_addr) == g;
            assign cpu_cnt_wr  = wr_evt && is_chan_reg(s_addr) &&
                                 s_addr[0] && chan_of(s_addr) == g;
            assign mine        = step && ch == g;
            assign reload      = mine && tc_now && mode[g][MODE_AUTOINIT];

            always_ff @(posedge I_CORE_CLK or negedge I_ARST_N)
            begin
                if (!I_ARST_N)
                    mode[g] <= MODE_RESET;
                else if (wr_evt && s_addr == OFS_MODE && s_data[1:0] == g)
                    mode[g] <= s_data[7:2];
            end

            // CPU writes win over the engine; software disables first.
            always_ff @(posedge I_CORE_CLK or negedge I_ARST_N)
            begin
                if (!I_ARST_N)
                begin
                    cur_addr[g]  <= '0;
                    base_addr[g] <= '0;
                end
                else if (cpu_addr_wr)
                begin
                    if (high_byte)
                    begin
                        cur_addr[g][15:8]  <= s_data;
                        base_addr[g][15:8] <= s_data;
                    end
                    else
                    begin
                        cur_addr[g][7:0]  <= s_data;
                        base_addr[g][7:0] <= s_data;
                    end
                end
                else if (reload)
                    cur_addr[g] <= base_addr[g];
                else if (mine && !(g == 0 && command[CMD_ADDR_HOLD]))
                    cur_addr[g] <= mode[g][MODE_DOWN] ?
                                   cur_addr[g] - 16'h0001 :
                                   cur_addr[g] + 16'h0001;
            end

            always_ff @(posedge I_CORE_CLK or negedge I_ARST_N)
            begin
                if (!I_ARST_N)
                begin
                    cur_count[g]  <= '0;
                    base_count[g] <= '0;
                end
                else if (cpu_cnt_wr)
                begin
                    if (high_byte)
                    begin
                        cur_count[g][15:8]  <= s_data;
                        base_count[g][15:8] <= s_data;
                    end
                    else
                    begin
                        cur_count[g][7:0]  <= s_data;
                        base_count[g][7:0] <= s_data;
                    end
                end
                else if (reload)
                    cur_count[g] <= base_count[g];
                else if (mine)
                    cur_count[g] <= cur_count[g] - 16'h0001;
            end

            // Writing the count's high byte re-arms a channel; the mask set
            // wins over an arming write in the same cycle.
            always_ff @(posedge I_CORE_CLK or negedge I_ARST_N)
            begin
                if (!I_ARST_N)
                    mask[g] <= 1'b1;
                else if (mine && tc_now && !mode[g][MODE_AUTOINIT])
                    mask[g] <= 1'b1;
                else if (wr_evt && s_addr == OFS_MASTER_CLR)
                    mask[g] <= 1'b1;
                else if (cpu_cnt_wr && high_byte)
                    mask[g] <= 1'b0;
            end

            assign req_eff[g] = (s_req[g] ^ command[CMD_REQ_LOW]) &&
                                !mask[g];
        end
    endgenerate

    always_ff @(posedge I_CORE_CLK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
        begin
            O_DATA    <= 8'h00;
            O_DATA_OE <= 1'b0;
        end
        else
        begin
            O_DATA_OE <= ior_act;
            if (rd_evt)
            begin
                if (is_chan_reg(s_addr))
                begin
                    if (s_addr[0])
                        O_DATA <= high_byte ?
                                  cur_count[chan_of(s_addr)][15:8] :
                                  cur_count[chan_of(s_addr)][7:0];
                    else
                        O_DATA <= high_byte ?
                                  cur_addr[chan_of(s_addr)][15:8] :
                                  cur_addr[chan_of(s_addr)][7:0];
                end
                else if (s_addr == OFS_COMMAND)
                    O_DATA <= command;
                else if (s_addr == OFS_MODE)
                    O_DATA <= {mode[mode_rd_idx], MODE_RD_CHAN};
                else
                    O_DATA <= 8'h00;
            end
        end
    end

    dcr_arbiter #(.N(CH_NUM)) u_arb (
        .i_req    (req_eff),
        .i_rotate (command[CMD_ROTATE]),
        .i_last   (last_ch),
        .o_valid  (arb_valid),
        .o_pick   (arb_pick)
    );

    dcr_stream_if #(.W(XFER_W)) rec_in ();
    dcr_stream_if #(.W(XFER_W)) rec_out ();

    dcr_fifo #(.W(XFER_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .i_clk   (I_CORE_CLK),
        .i_rst_n (I_ARST_N),
        .in_s    (rec_in),
        .out_s   (rec_out)
    );

    assign rec_in.valid = step;
    assign rec_in.data  = {tc_now, ch, cur_addr[ch]};
    assign rec_out.ready = !O_XFER_VALID || I_XFER_READY;

    always_ff @(posedge I_CORE_CLK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
        begin
            O_XFER_VALID <= 1'b0;
            O_XFER_ADDR  <= '0;
            O_XFER_CHAN  <= '0;
            O_XFER_TC    <= 1'b0;
        end
        else if (rec_out.ready)
        begin
            O_XFER_VALID <= rec_out.valid;
            {O_XFER_TC, O_XFER_CHAN, O_XFER_ADDR} <= rec_out.data;
        end
    end

    // A record is pushed in S4; S1 waits for room so no record is lost.
    always_comb
    begin
        next_state = state;
        case (state)
            DCR_ST_IDLE:
                if (!disabled && arb_valid)
                    next_state = (dcr_svc_t'(mode[arb_pick][MODE_SVC_LSB +: 2])
                                  == DCR_SV_CASC) ? DCR_ST_CASC : DCR_ST_S1;
            DCR_ST_S1:
                if (rec_in.ready && !disabled)
                    next_state = DCR_ST_S2;
            DCR_ST_S2:
                next_state = DCR_ST_S3;
            DCR_ST_S3:
                next_state = DCR_ST_S4;
            DCR_ST_S4:
                if (!disabled && !tc_now &&
                    (svc == DCR_SV_BLOCK ||
                     (svc == DCR_SV_DEMAND && req_eff[ch])))
                    next_state = DCR_ST_S1;
                else
                    next_state = DCR_ST_IDLE;
            DCR_ST_CASC:
                if (!req_eff[ch])
                    next_state = DCR_ST_IDLE;
            default:
                next_state = DCR_ST_IDLE;
        endcase
    end

    always_ff @(posedge I_CORE_CLK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
        begin
            state   <= DCR_ST_IDLE;
            ch      <= '0;
            last_ch <= CH_W'(CH_NUM - 1);
        end
        else
        begin
            state <= next_state;
            if (state == DCR_ST_IDLE && next_state != DCR_ST_IDLE)
            begin
                ch      <= arb_pick;
                last_ch <= arb_pick;
            end
        end
    end

    assign rd_win = (next_state == DCR_ST_S2 || next_state == DCR_ST_S3);
    // Extended write opens the write strobe one clock early, in S2.
    assign wr_win = (next_state == DCR_ST_S3) ||
                    (next_state == DCR_ST_S2 && command[CMD_EXT_WRITE]);

    // Strobes follow the next state so they line up with it.
    always_ff @(posedge I_CORE_CLK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
        begin
            O_MEM_RD <= 1'b0;
            O_MEM_WR <= 1'b0;
            O_IO_RD  <= 1'b0;
            O_IO_WR  <= 1'b0;
            O_TC     <= 1'b0;
        end
        else
        begin
            O_MEM_RD <= rd_win && xtype == DCR_XF_READ;
            O_IO_WR  <= wr_win && xtype == DCR_XF_READ;
            O_IO_RD  <= rd_win && xtype == DCR_XF_WRITE;
            O_MEM_WR <= wr_win && xtype == DCR_XF_WRITE;
            O_TC     <= tc_now;
        end
    end

    always_ff @(posedge I_CORE_CLK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
            O_CHANNEL_ACKNOWLEDGE_LINE <= {CH_NUM{1'b1}};
        else
        begin
            for (int i = 0; i < CH_NUM; i++)
                O_CHANNEL_ACKNOWLEDGE_LINE[i] <=
                    (state != DCR_ST_IDLE && ch == i) ==
                    command[CMD_ACK_HIGH];
        end
    end
endmodule
`default_nettype wire

/* testbench/dcr_top_assertions.sv */
// Port-level checks of the DMA register block.
// Assumes a bind onto dcr_top, whose port names it shares.
`default_nettype none
module dcr_top_assertions
    import dcr_pkg::*;
(
    input wire logic              I_CORE_CLK,
    input wire logic              I_ARST_N,
    input wire logic              I_IOR_N,
    input wire logic [3:0]        I_ADDR,
    input wire logic [7:0]        O_DATA,
    input wire logic              O_DATA_OE,
    input wire logic [CH_NUM-1:0] O_CHANNEL_ACKNOWLEDGE_LINE,
    input wire logic              O_TC,
    input wire logic              O_MEM_RD,
    input wire logic              O_MEM_WR,
    input wire logic              O_IO_RD,
    input wire logic              O_IO_WR,
    input wire logic              O_XFER_VALID,
    input wire logic [ADDR_W-1:0] O_XFER_ADDR,
    input wire logic [CH_W-1:0]   O_XFER_CHAN,
    input wire logic              I_XFER_READY
);
    default clocking dc @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_ARST_N);
    sequence s_rd_go;
        $fell(I_IOR_N);
    endsequence
    sequence s_rd_gap;
        ##4 (O_DATA == 8'h00);
    endsequence
    a_tc_one_pulse:
        assert property (O_TC |=> !O_TC) else $error("tc too long");
    a_ack_one_only:
        assert property ($countones(O_CHANNEL_ACKNOWLEDGE_LINE) inside
            {0, 1, 3, 4}) else $error("ack not one-hot");
    a_rec_held_stall:
        assert property (O_XFER_VALID && !I_XFER_READY |=> O_XFER_VALID &&
            $stable(O_XFER_ADDR) && $stable(O_XFER_CHAN))
        else $error("record dropped");
    a_mem_dir_excl:
        assert property (!(O_MEM_RD && O_MEM_WR)) else $error("mem rd+wr");
    a_io_dir_excl:
        assert property (!(O_IO_RD && O_IO_WR)) else $error("io rd+wr");
    a_read_oe_rise:
        assert property (s_rd_go |-> ##[3:4] O_DATA_OE) else $error("no oe");
    a_read_oe_fall:
        assert property ($rose(I_IOR_N) |-> ##[2:4] !O_DATA_OE)
        else $error("oe stuck");
    a_gap_reads_zero:
        assert property (s_rd_go ##0 (I_ADDR == 4'h9) |-> s_rd_gap)
        else $error("unmapped read not zero");
endmodule
`default_nettype wire

/* testbench/dcr_periph.sv */
// Peripheral model: raises channel 0 request and stalls the record sink.
// Assumes the bench sets the line level to suit the request polarity.
`default_nettype none
module dcr_periph (
    input  wire logic       i_clk,
    input  wire logic       i_req_on,
    output logic [3:0]      o_req,
    output var logic        o_ready = 1'b0
);
    assign o_req = {3'b000, i_req_on};
    // Half-rate ready keeps the record FIFO under back-pressure.
    always @(negedge i_clk)
        o_ready <= ~o_ready;
endmodule
`default_nettype wire

/* testbench/dma_channel_registers_bench.sv */
// Self-checking bench of the DMA register block and its peripheral model.
// Assumes dcr_top, its checker and dcr_periph are compiled before it.
`default_nettype none
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin \
    err_total++; $display("mismatch %s exp %h got %h", n, e, a); end end
module dma_channel_registers_bench;
    import dcr_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 0, rst_n = 0, ior_n = 1, iow_n = 1, req_on = 0;
    logic [3:0]  addr = 0, req, ack;
    logic [7:0]  wdata = 0, rdata, o_data;
    logic [15:0] x_addr;
    logic [1:0]  x_chan;
    logic        tc, x_valid, x_tc, ready, io_wr, mem_rd;
    int          err_total = 0, check_count = 0, nrec = 0, ntc = 0;
    int          nwr = 0, nrd = 0, dir = 1, rec0 = 0, tc_at = 2;
    logic [15:0] base_a = 16'h12FE;
    // Row: nibble 3 is write, nibble 2 offset, low byte data or expected.
    logic [15:0] rows [21] = '{16'h0800, 16'h1C00, 16'h1034, 16'h1012,
        16'h1C00, 16'h0034, 16'h0012, 16'h1850, 16'h0850, 16'h1B88,
        16'h1B45, 16'h1B02, 16'h1BD7, 16'h1E00, 16'h0B8B, 16'h0B47,
        16'h0B03, 16'h0BD7, 16'h0900, 16'h1D00, 16'h0800};
    dcr_top dut (.I_CORE_CLK(clk), .I_ARST_N(rst_n), .I_IOR_N(ior_n),
        .I_IOW_N(iow_n), .I_ADDR(addr), .I_DATA(wdata), .O_DATA(o_data),
        .O_DATA_OE(), .I_CHANNEL_REQUEST_LINE(req),
        .O_CHANNEL_ACKNOWLEDGE_LINE(ack), .O_TC(tc), .O_MEM_RD(mem_rd),
        .O_MEM_WR(), .O_IO_RD(), .O_IO_WR(io_wr), .O_XFER_VALID(x_valid),
        .O_XFER_ADDR(x_addr), .O_XFER_CHAN(x_chan), .O_XFER_TC(x_tc),
        .I_XFER_READY(ready));
    dcr_periph peer (.i_clk(clk), .i_req_on(req_on), .o_req(req),
        .o_ready(ready));
    initial forever #20 clk = ~clk;
    task automatic io(input logic w, input logic [3:0] a,
                      input logic [7:0] d);
        @(negedge clk);
        addr = a;
        wdata = d;
        repeat (2) @(negedge clk);
        if (w) iow_n = 0;
        else ior_n = 0;
        repeat (6) @(negedge clk);
        rdata = o_data;
        iow_n = 1;
        ior_n = 1;
        repeat (4) @(negedge clk);
    endtask
    // Holds the request only until the grant, so a block ends at its own TC.
    task automatic burst();
        req_on = 0;
        wait (ack[0] === 1'b1);
        @(negedge clk);
        req_on = 1;
        repeat (60) @(negedge clk);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge clk)
    begin
        if (tc) ntc++;
        if (io_wr) nwr++;
        if (mem_rd) nrd++;
        if (x_valid && ready)
        begin
            `CHK("rec addr", base_a + 16'(dir * (nrec - rec0)), x_addr)
            `CHK("rec chan", 2'h0, x_chan)
            `CHK("rec last", nrec == tc_at, x_tc)
            nrec++;
        end
    end
    initial
    begin
        repeat (3000) @(posedge clk);
        err_total++;
        tally_and_finish();
    end
    initial
    begin
        repeat (10) @(negedge clk);
        rst_n = 1;
        foreach (rows[i])
        begin
            io(rows[i][12], rows[i][11:8], rows[i][7:0]);
            if (!rows[i][12]) `CHK("reg", rows[i][7:0], rdata)
        end
        io(1, 4'h8, 8'h04);
        io(1, 4'hB, 8'h88);
        io(1, 4'h0, 8'hFE);
        io(1, 4'h0, 8'h12);
        io(1, 4'h1, 8'h02);
        io(1, 4'h1, 8'h00);
        req_on = 1;
        repeat (40) @(negedge clk);
        `CHK("ack held off", 4'hF, ack)
        io(1, 4'h8, 8'h00);
        repeat (120) @(negedge clk);
        `CHK("records", 3, nrec)
        `CHK("tc pulses", 1, ntc)
        `CHK("ack masked", 4'hF, ack)
        io(1, 4'h8, 8'hE0);
        `CHK("ack high idle", 4'h0, ack)
        io(1, 4'hB, 8'hB8);
        io(1, 4'h0, 8'h20);
        io(1, 4'h0, 8'h00);
        io(1, 4'h1, 8'h01);
        io(1, 4'h1, 8'h00);
        repeat (40) @(negedge clk);
        `CHK("high line idle", 3, nrec)
        base_a = 16'h0020;
        dir = -1;
        rec0 = 3;
        tc_at = 4;
        burst();
        io(0, 4'h0, 8'h00);
        `CHK("addr reload", 8'h20, rdata)
        io(0, 4'h0, 8'h00);
        `CHK("addr reload hi", 8'h00, rdata)
        io(0, 4'h1, 8'h00);
        `CHK("count reload", 8'h01, rdata)
        io(0, 4'h1, 8'h00);
        `CHK("count reload hi", 8'h00, rdata)
        io(1, 4'h8, 8'hE2);
        dir = 0;
        rec0 = 5;
        tc_at = 6;
        burst();
        `CHK("records all", 7, nrec)
        `CHK("tc pulses all", 3, ntc)
        `CHK("ack idle", 4'h0, ack)
        `CHK("io wr cycles", 11, nwr)
        `CHK("mem rd cycles", 14, nrd)
        rst_n = 0;
        repeat (3) @(negedge clk);
        rst_n = 1;
        @(negedge clk);
        `CHK("reset ack", 4'hF, ack)
        `CHK("reset tc", 1'b0, tc)
        `CHK("reset record", 1'b0, x_valid)
        io(0, 4'h8, 8'h00);
        `CHK("reset command", 8'h00, rdata)
        tally_and_finish();
    end
endmodule
bind dcr_top dcr_top_assertions chk (.*);
`default_nettype wire
